// ===== rtl/gpm_pkg.sv
// Purpose: shared constants and types for the five-port pin mode block
// Assumes: 50 MHz system clock, synchronous active-low reset
// Notes:   one two-bit mode field and one data bit per pin
package gpm_pkg;
  localparam int PORT_CNT     = 5;                       // number of ports
  localparam int PORT_W       = 8;                       // pins per port
  localparam int PIN_CNT      = PORT_CNT * PORT_W;       // forty pins in all
  localparam int MODE_W       = 2;                       // width of one pin mode field
  localparam logic [PORT_W-1:0] DOUT_RST = 8'hff;        // output bits after reset
  localparam int BOOST_CYC    = 2;                       // strong-high cycles in quasi mode
  localparam int BOOST_CNT_W  = 2;                       // width of the boost counter
  typedef enum logic [1:0] {
    GPM_MODE_INPUT = 2'b00,                              // high impedance
    GPM_MODE_PUSH  = 2'b01,                              // push-pull
    GPM_MODE_OPEN  = 2'b10,                              // open-drain
    GPM_MODE_QUASI = 2'b11                               // quasi-bidirectional
  } gpm_mode_t;
  localparam gpm_mode_t MODE_RST = GPM_MODE_QUASI;       // mode after reset
endpackage

// ===== rtl/gpm_pin_cell.sv
// Purpose: drive logic for one pin in one of four modes
// Assumes: pin_level is already synchronised to clk_sys
// Notes:   strong high in quasi mode lasts a fixed number of cycles
`timescale 1ns/1ps
module gpm_pin_cell
  import gpm_pkg::*;
(
  input  wire logic      clk_sys,      // system clock
  input  wire logic      rst_n,        // synchronous reset, active low
  input  wire gpm_mode_t pin_mode,     // this pin's mode field
  input  wire logic      out_bit,      // this pin's output data bit
  input  wire logic      pin_level,    // synchronised pin level
  output logic           pad_o,        // value driven on the pad
  output logic           pad_oe        // high while the pad is driven
);
  // boost state: tracks the strong-high drive; boost_cnt_r counts cycles done
  typedef enum logic [1:0] {
    GPM_Q_IDLE  = 2'b00,               // no strong drive
    GPM_Q_BOOST = 2'b01,               // strong high in progress
    GPM_Q_HOLD  = 2'b10                // waiting for the pin to read high again
  } gpm_qstate_t;

  gpm_qstate_t            qstate_r;    // boost state
  logic [BOOST_CNT_W-1:0] boost_cnt_r; // cycles of strong drive done
  logic                   quasi_hi;    // quasi mode with data one

  assign quasi_hi = (pin_mode == GPM_MODE_QUASI) && out_bit;

  // strong high only after a low pin is seen, and only for a fixed span;
  // hold state stops a slow external edge from retriggering every cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      qstate_r    <= GPM_Q_IDLE;
      boost_cnt_r <= '0;
    end else if (!quasi_hi) begin
      qstate_r    <= GPM_Q_IDLE;
      boost_cnt_r <= '0;
    end else begin
      unique case (qstate_r)
        GPM_Q_IDLE: begin
          if (!pin_level) begin // RULE7
            qstate_r    <= GPM_Q_BOOST;
            boost_cnt_r <= '0;
          end
        end
        GPM_Q_BOOST: begin
          if (boost_cnt_r == BOOST_CNT_W'(BOOST_CYC - 1)) begin // RULE7
            qstate_r <= GPM_Q_HOLD;
          end else begin
            boost_cnt_r <= boost_cnt_r + 1'b1;
          end
        end
        GPM_Q_HOLD: begin
          // the synchroniser still shows the old low right after release
          if (pin_level) begin
            qstate_r <= GPM_Q_IDLE;
          end
        end
        default: begin
          qstate_r <= GPM_Q_IDLE;
        end
      endcase
    end
  end

  // pad drive per mode
  always_comb begin
    pad_o  = 1'b0;
    pad_oe = 1'b0;
    unique case (pin_mode)
      GPM_MODE_INPUT: begin
        pad_oe = 1'b0; // RULE3
      end
      GPM_MODE_PUSH: begin
        pad_o  = out_bit; // RULE4
        pad_oe = 1'b1;
      end
      GPM_MODE_OPEN: begin
        pad_o  = 1'b0; // RULE5
        pad_oe = !out_bit;
      end
      GPM_MODE_QUASI: begin
        pad_o  = out_bit; // RULE6
        pad_oe = !out_bit || (qstate_r == GPM_Q_BOOST); // RULE7
      end
    endcase
  end

  // strong high lasts exactly two cycles once started
  sequence s_boost_start;
    (qstate_r == GPM_Q_IDLE) && quasi_hi && !pin_level;
  endsequence
  sequence s_boost_span;
    s_boost_start ##1 quasi_hi [*3];
  endsequence
  a_quasi_boost_len: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
    s_boost_span |-> $past(pad_oe, 1) && $past(pad_oe, 2) && $past(pad_o, 1) && !pad_oe)
    else $error("quasi boost length wrong");
endmodule

// ===== rtl/gpm_port_top.sv
// Purpose: forty-pin, five-port mode and data logic
// Assumes: pads resolved outside; pull-ups on the board
// Notes:   mode and data arrive as plain ports, no register bus
// Notes on behaviour
// RULE1: forty pins, five ports, per-pin control
// RULE2: reset: quasi mode, output bits all ones
// RULE3: mode 00 floats pin, level still read
// RULE4: mode 01 drives data push-pull
// RULE5: mode 10 sinks low, releases high
// RULE6: mode 11 quasi, zero data drives low
// RULE7: quasi one: low pin gets two-cycle boost
// RULE8: software sets data one before input
// RULE9: pin levels sampled every clock
`timescale 1ns/1ps
module gpm_port_top
  import gpm_pkg::*;
(
  input  wire logic                            clk_sys,                // system clock
  input  wire logic                            rst_n,                  // sync reset, low
  input  wire logic [PIN_CNT*MODE_W-1:0]       port_pin_mode_select,   // new mode fields
  input  wire logic                            mode_wr,                // load mode fields
  input  wire logic [PIN_CNT-1:0]              port_output_bits_wdata, // new output bits
  input  wire logic                            dout_wr,                // load output bits
  input  wire logic [PIN_CNT-1:0]              pad_i,                  // pad levels
  output logic      [PIN_CNT-1:0]              pad_o,                  // pad drive values
  output logic      [PIN_CNT-1:0]              pad_oe,                 // pad drive enables
  output logic      [PIN_CNT*MODE_W-1:0]       mode_q,                 // held mode fields
  output logic      [PIN_CNT-1:0]              port_output_bits,       // held output bits
  output logic      [PIN_CNT-1:0]              port_pin_level_bits     // sampled levels
);
  logic [PIN_CNT-1:0]        sync1_r;      // first synchroniser stage
  logic [PIN_CNT*MODE_W-1:0] mode_rst_vec; // reset image of the mode fields

  // mode fields: all quasi after reset
  assign mode_rst_vec = {PIN_CNT{MODE_RST}};
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_q <= {PIN_CNT{MODE_RST}}; // RULE2
    end else if (mode_wr) begin
      mode_q <= port_pin_mode_select; // RULE1
    end
  end

  // output bits: each port resets to all ones
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      port_output_bits <= {PORT_CNT{DOUT_RST}}; // RULE2
    end else if (dout_wr) begin
      port_output_bits <= port_output_bits_wdata;
    end
  end

  // two-stage sample of pads every clock in any mode;
  // resets to the pull-up level so release does not look like a low pin
  // and start a false boost on every quasi pin
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_r             <= '1;
      port_pin_level_bits <= '1;
    end else begin
      sync1_r             <= pad_i; // RULE9
      port_pin_level_bits <= sync1_r; // RULE3
    end
  end

  // one drive cell per pin
  for (genvar i = 0; i < PIN_CNT; i++) begin : g_pin
    gpm_pin_cell u_cell (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .pin_mode  (gpm_mode_t'(mode_q[i*MODE_W +: MODE_W])),
      .out_bit   (port_output_bits[i]),
      .pin_level (port_pin_level_bits[i]),
      .pad_o     (pad_o[i]),
      .pad_oe    (pad_oe[i])
    );
  end

  // input mode never drives the pad
  a_input_float: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q[1:0] == 2'b00 |-> !pad_oe[0]) // RULE3
    else $error("pin driven in input mode");
  // push-pull follows the data bit
  a_push_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q[1:0] == 2'b01 |-> pad_oe[0] && pad_o[0] == port_output_bits[0]) // RULE4
    else $error("push-pull drive wrong");
  // open-drain only ever sinks
  a_open_sink: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q[1:0] == 2'b10 |-> !pad_o[0] && pad_oe[0] == !port_output_bits[0]) // RULE5
    else $error("open-drain drive wrong");
  // quasi with zero data holds low
  a_quasi_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q[1:0] == 2'b11 && !port_output_bits[0] |-> pad_oe[0] && !pad_o[0]) // RULE6
    else $error("quasi zero not driven low");
  // pin level follows pad after two clocks
  a_level_sample: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n, 1) && $past(rst_n, 2) |-> port_pin_level_bits == $past(pad_i, 2)) // RULE9
    else $error("pin level not sampled");
  // first clock out of reset shows reset images
  a_reset_image: assert property (@(posedge clk_sys)
    rst_n && $past(!rst_n) |-> mode_q == mode_rst_vec && &port_output_bits) // RULE2
    else $error("reset values wrong");
  // quasi one with high pin and no boost is released
  a_quasi_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q[1:0] == 2'b11 && port_output_bits[0] && $past(mode_q[1:0]) == 2'b11
    && $past(port_output_bits[0]) && $past(port_pin_level_bits[0], 1)
    && $past(port_pin_level_bits[0], 2) |-> !pad_oe[0]) // RULE7
    else $error("quasi high driven without cause");
  // the last pin of the last port has its own field and data bit
  a_pin_count: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
    mode_q[PIN_CNT*MODE_W-1 -: MODE_W] == 2'b01
    |-> pad_oe[PIN_CNT-1] && pad_o[PIN_CNT-1] == port_output_bits[PIN_CNT-1])
    else $error("last pin drive wrong");
endmodule

// ===== tb/gpm_board_model.sv
// Purpose: board side of the forty pads, pull-ups plus bench-controlled sinks
// Assumes: every pad has a pull-up on the board
// Notes:   a pad driven by the block wins over a sink; no contention model
`timescale 1ns/1ps
module gpm_board_model (
  input  wire logic [gpm_pkg::PIN_CNT-1:0] pad_o,     // block drive values
  input  wire logic [gpm_pkg::PIN_CNT-1:0] pad_oe,    // block drive enables
  input  wire logic [gpm_pkg::PIN_CNT-1:0] ext_sink,  // outside part pulling low
  output logic      [gpm_pkg::PIN_CNT-1:0] pad_lvl    // resolved pad level
);
  import gpm_pkg::*;
  // a released pad floats up through its pull-up unless something sinks it
  always_comb begin
    for (int i = 0; i < PIN_CNT; i++) begin
      pad_lvl[i] = pad_oe[i] ? pad_o[i] : ~ext_sink[i];
    end
  end
endmodule

// ===== tb/tb.sv
// Purpose: self-checking bench for the forty-pin mode block
// Assumes: 50 MHz clock, inputs driven on the falling edge
// Notes:   table rows first, then mid-run reset and quasi boost cases
`timescale 1ns/1ps
module tb;
  import gpm_pkg::*;
  typedef struct {
    logic [79:0] m;                          // mode fields
    logic [39:0] d, s, oe, o, lv;            // data, sinks, expected results
  } gpm_row_t;
  localparam logic [39:0] DV = 40'h5a_c3_0f_96_e1; // data pattern
  localparam logic [39:0] SV = 40'h0f_f0_33_cc_0f; // sink pattern
  localparam logic [39:0] EV = 40'h55_55_55_55_55; // even pins
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [79:0] mode_sel = '0;
  logic        mode_wr = 1'b0;
  logic [39:0] dout_wd = '0;
  logic        dout_wr = 1'b0;
  logic [39:0] ext_sink = '0;
  logic [39:0] pad_lvl, pad_o, pad_oe, port_output_bits, port_pin_level_bits;
  logic [79:0] mode_q;
  gpm_row_t    rows [5];
  int          errors = 0;
  int          compares = 0;
  int          k, n;
  always #10 clk_sys = ~clk_sys;
  gpm_port_top gpm_port_top_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .port_pin_mode_select(mode_sel), .mode_wr(mode_wr),
    .port_output_bits_wdata(dout_wd), .dout_wr(dout_wr), .pad_i(pad_lvl),
    .pad_o(pad_o), .pad_oe(pad_oe), .mode_q(mode_q),
    .port_output_bits(port_output_bits), .port_pin_level_bits(port_pin_level_bits));
  gpm_board_model gpm_board_model_i (.pad_o(pad_o), .pad_oe(pad_oe),
    .ext_sink(ext_sink), .pad_lvl(pad_lvl));
  // case equality so an unknown never counts as a match
  task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    rows[0] = '{{40{GPM_MODE_INPUT}}, DV, SV, '0, '0, ~SV};
    rows[1] = '{{40{GPM_MODE_PUSH}}, DV, '0, '1, DV, DV};
    rows[2] = '{{40{GPM_MODE_OPEN}}, DV, '0, ~DV, '0, DV};
    rows[3] = '{{40{GPM_MODE_QUASI}}, DV, '0, ~DV, '0, DV};
    rows[4] = '{{20{2'b00, 2'b01}}, DV, SV, EV, DV, (DV & EV) | (~SV & ~EV)};
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    // load both registers in one write, give the pads two flops to settle
    foreach (rows[i]) begin
      mode_sel = rows[i].m;
      dout_wd = rows[i].d;
      ext_sink = rows[i].s;
      mode_wr = 1'b1;
      dout_wr = 1'b1;
      @(negedge clk_sys);
      mode_wr = 1'b0;
      dout_wr = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk(mode_q, rows[i].m, "mode fields");
      chk(port_output_bits, rows[i].d, "output bits");
      chk(pad_oe, rows[i].oe, "drive enables");
      chk(pad_o & pad_oe, rows[i].o & rows[i].oe, "drive values");
      chk(port_pin_level_bits, rows[i].lv, "pin levels");
      $display("row %0d done", i);
    end
    // reset in mid-run must bring back quasi mode and all-ones data
    rst_n = 1'b0;
    ext_sink = '0;
    repeat (2) @(negedge clk_sys);
    chk(mode_q, {40{MODE_RST}}, "reset modes");
    chk(port_output_bits, {5{DOUT_RST}}, "reset data");
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(pad_oe, '0, "no drive after reset");
    repeat (6) @(negedge clk_sys);
    $display("reset test done");
    // data bits are ones from reset, so sinking pin 3 low starts a quasi boost whose length is timed
    ext_sink[3] = 1'b1;
    for (k = 0; k < 10 && pad_oe[3] !== 1'b1; k++) @(negedge clk_sys);
    if (k == 10) begin
      errors++;
      test_done();
    end
    for (n = 0; n < 8 && pad_oe[3] === 1'b1 && pad_o[3] === 1'b1; n++) @(negedge clk_sys);
    chk(80'(n), 80'(BOOST_CYC), "boost length");
    chk(pad_oe & ~40'h08, '0, "other pins idle");
    ext_sink = '0;
    $display("boost test done");
    test_done();
  end
endmodule
